// [hdl/fra_cfg.svh]
// Constants for the fragment reassembly receiver: sizes, limits, timing.
// Assumes inclusion by bare name from the package and the design modules.
//
// Behaviour
// - One queue per channel, one reassembly buffer
// - Only good fragments enter channel queues
// - Sequence compare is wrap-aware, half-space window
// - No sequencing errors while expected is unknown
// - Expected set from head minimum after fill/timeout
// - Candidate is the smallest head sequence number
// - Per-queue bit-time timers; processing restarts all
// - Initialise on first link-up from all-down
// - Candidate equal expected is processed and accepted
// - Below, full-mismatch or timeout invoke sequence handling
// - Overflow, early start, stray end, absent start fault
// - Good end-flagged fragment completes frame to MAC
// - Expected increments modulo 14-bit space
// - Channel buffering of 2^14 bits
// - Header: 14-bit sequence, start, end flags
// - Unrecoverable frame becomes 64 zero octets, errored
// - Absent start: discard, substitute frame, lost-start
// - Overflow when frame would exceed 1522 octets
`ifndef FRA_CFG_SVH
`define FRA_CFG_SVH

`define FRA_SEQ_W 14
`define FRA_SEQ_HALF 14'h2000
`define FRA_LEN_W 10
`define FRA_FRAME_W 11
`define FRA_MAX_SKEW_BITS 14'h3A98
`define FRA_MAX_RATE_RATIO 4
`define FRA_MIN_PIECE 10'h040
`define FRA_LARGEST_PIECE 10'h200
`define FRA_MAX_FRAME 16'h05F2
`define FRA_SUBST_LEN 11'h040
`define FRA_CHAN_BUF_BITS 16'h4000
`define FRA_NUM_CHAN 4
`define FRA_QUEUE_DEPTH 8
`define FRA_OUT_DEPTH 8
`define FRA_DIV_W 16

`endif

// [hdl/fra_pkg.sv]
// Types shared by the fragment reassembly receiver and its output FIFO.
// Assumes fra_cfg.svh is on the include path.
`include "fra_cfg.svh"

package fra_pkg;

    // Fragment header: sequence, start flag, end flag, length
    typedef struct packed {
        logic [`FRA_SEQ_W-1:0] seq;
        logic first_piece_flag;
        logic last_piece_flag;
        logic [`FRA_LEN_W-1:0] len;
    } fra_frag_t;

    // One frame record toward the rate matcher
    typedef struct packed {
        logic [`FRA_FRAME_W-1:0] len;
        logic rx_err;
        logic substitute;
    } fra_rec_t;

    // Receive sequencing states
    typedef enum logic {
        FRA_INIT_STATE,
        FRA_RUN
    } fra_rx_state_t;

endpackage : fra_pkg

// [hdl/fra_fifo.sv]
// Synchronous FIFO for frame records in front of the rate matcher.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module fra_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import fra_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // Whole FIFO state
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } fifo_state_t;

    fifo_state_t s_reg;
    fifo_state_t s_next;
    logic push;
    logic pop;

    // Honest flags straight from the count
    assign in_ready = (s_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_reg.cnt != '0);
    assign out_data = s_reg.mem[s_reg.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wr] = in_data;
            s_next.wr = (s_reg.wr == AW'(DEPTH - 1)) ? '0 : s_reg.wr + 1'b1;
        end
        if (pop) begin
            s_next.rd = (s_reg.rd == AW'(DEPTH - 1)) ? '0 : s_reg.rd + 1'b1;
        end
        s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Register the state
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule : fra_fifo

`default_nettype wire

// [hdl/fra_receiver.sv]
// Receive side of loop aggregation: per-channel queues, sequencing,
// reassembly into frame records toward the rate matcher.
// Assumes channel inputs come from logic on mclk; payload octets travel
// on a companion path steered by the records this block emits.
`timescale 1ns/1ps
`default_nettype none
`include "fra_cfg.svh"

module fra_receiver #(
    parameter int NCH = `FRA_NUM_CHAN,
    parameter int QDEPTH = `FRA_QUEUE_DEPTH,
    parameter int ODEPTH = `FRA_OUT_DEPTH,
    parameter logic [13:0] SKEW_BITS = `FRA_MAX_SKEW_BITS
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [NCH-1:0] channel_link_up,
    input wire logic [NCH-1:0] chan_in_valid,
    input wire logic [NCH-1:0] chan_in_bad,
    input wire fra_pkg::fra_frag_t [NCH-1:0] chan_in_frag,
    input wire logic [NCH-1:0][`FRA_DIV_W-1:0] chan_bit_div,
    input wire logic mac_out_ready,
    output logic mac_out_valid,
    output fra_pkg::fra_rec_t mac_out_rec,
    output logic [NCH-1:0] frag_dropped,
    output logic seq_known,
    output logic bad_fragment,
    output logic lost_fragment,
    output logic lost_first_flag,
    output logic reassembly_too_long,
    output logic early_start_seen,
    output logic stray_end_seen,
    output logic absent_start_seen
);
    import fra_pkg::*;

    localparam int AW = $clog2(QDEPTH);
    localparam int SW = `FRA_SEQ_W;
    localparam int RW = $bits(fra_rec_t);

    // Whole block state except the output FIFO in one record
    typedef struct packed {
        fra_rx_state_t st;
        logic [SW-1:0] expected_seq;
        logic in_frame;
        logic flushing;
        logic [`FRA_FRAME_W-1:0] frame_len;
        logic [NCH-1:0][QDEPTH-1:0] [$bits(fra_frag_t)-1:0] mem;
        logic [NCH-1:0][AW-1:0] rd;
        logic [NCH-1:0][AW-1:0] wr;
        logic [NCH-1:0][AW:0] cnt;
        logic [NCH-1:0][15:0] fill_bits;
        logic [NCH-1:0][`FRA_DIV_W-1:0] div;
        logic [NCH-1:0][13:0] tmr;
        logic link_any;
        logic [NCH-1:0] dropped;
        logic bad;
        logic lost;
        logic lost_first;
        logic too_long;
        logic early;
        logic stray;
        logic absent;
        logic out_valid;
        fra_rec_t out_rec;
    } rx_state_t;

    rx_state_t s_reg;
    rx_state_t s_next;

    // Handshake with the output FIFO
    logic push;
    fra_rec_t push_rec;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [RW-1:0] fifo_out_data;

    // Head scan results
    logic have_head;
    logic every_queue_filled;
    logic stall_timeout;
    logic [SW-1:0] head_min_seq;
    logic [$clog2(NCH+1)-1:0] head_ch;
    fra_frag_t head_frag;

    // Wrap-aware less-than: x < y <= x + half the space
    function automatic logic seq_less(input logic [SW-1:0] x,
                                      input logic [SW-1:0] y);
        logic [SW-1:0] d;
        d = y - x;
        return (d != '0) && (d <= `FRA_SEQ_HALF);
    endfunction : seq_less

    // Octets to bits for buffer accounting
    function automatic logic [15:0] to_bits(input logic [`FRA_LEN_W-1:0] l);
        return {3'b000, l, 3'b000};
    endfunction : to_bits

    // Smallest head among active non-empty queues, fill and timeout
    always_comb begin
        fra_frag_t cand; // Head of the queue under scan
        cand = '0;
        have_head = 1'b0;
        every_queue_filled = 1'b1;
        stall_timeout = 1'b0;
        head_min_seq = '0;
        head_ch = '0;
        head_frag = '0;
        for (int i = 0; i < NCH; i++) begin
            if (channel_link_up[i]) begin
                if (s_reg.cnt[i] == '0) begin
                    every_queue_filled = 1'b0;
                end else begin
                    if (s_reg.tmr[i] >= SKEW_BITS) begin
                        stall_timeout = 1'b1;
                    end
                    cand = fra_frag_t'(s_reg.mem[i][s_reg.rd[i]]);
                    if (!have_head || seq_less(cand.seq, head_min_seq)) begin
                        have_head = 1'b1;
                        head_frag = cand;
                        head_min_seq = cand.seq;
                        head_ch = ($clog2(NCH+1))'(i);
                    end
                end
            end
        end
        every_queue_filled = every_queue_filled && have_head;
    end

    // Sequencing, reassembly, queue and timer update
    always_comb begin
        logic pop;
        logic restart;
        logic [15:0] sum;
        pop = 1'b0;
        restart = 1'b0;
        sum = 16'h0000;
        push = 1'b0;
        push_rec = '0;
        s_next = s_reg;
        // Status outputs other than seq_known are one-cycle pulses
        s_next.dropped = '0;
        s_next.bad = 1'b0;
        s_next.lost = 1'b0;
        s_next.lost_first = 1'b0;
        s_next.too_long = 1'b0;
        s_next.early = 1'b0;
        s_next.stray = 1'b0;
        s_next.absent = 1'b0;
        s_next.link_any = |channel_link_up;

        // Stall sequencing while the output FIFO is full
        if (have_head && fifo_in_ready) begin
            case (s_reg.st)
                FRA_INIT_STATE: begin
                    // Expected unknown: no sequencing faults here
                    if (every_queue_filled || stall_timeout) begin
                        s_next.expected_seq = head_min_seq;
                        s_next.st = FRA_RUN;
                        restart = 1'b1;
                    end
                end
                FRA_RUN: begin
                    if (head_min_seq == s_reg.expected_seq) begin
                        // Accept into the reassembly buffer
                        pop = 1'b1;
                        sum = 16'(s_reg.frame_len) + 16'(head_frag.len);
                        if (!s_reg.in_frame) begin
                            if (head_frag.first_piece_flag) begin
                                s_next.flushing = 1'b0;
                                if (head_frag.last_piece_flag) begin
                                    push = 1'b1;
                                    push_rec.len = `FRA_FRAME_W'(head_frag.len);
                                end else begin
                                    s_next.in_frame = 1'b1;
                                    s_next.frame_len = `FRA_FRAME_W'(head_frag.len);
                                end
                            end else if (!s_reg.flushing) begin
                                // Missing start between frames
                                push = 1'b1;
                                push_rec.len = `FRA_SUBST_LEN;
                                push_rec.rx_err = 1'b1;
                                push_rec.substitute = 1'b1;
                                s_next.lost_first = 1'b1;
                                s_next.absent = 1'b1;
                                s_next.stray = head_frag.last_piece_flag;
                            end
                        end else if (head_frag.first_piece_flag) begin
                            // Early start: close partial, retry head
                            pop = 1'b0;
                            push = 1'b1;
                            push_rec.len = s_reg.frame_len;
                            push_rec.rx_err = 1'b1;
                            s_next.in_frame = 1'b0;
                            s_next.early = 1'b1;
                        end else if (sum > `FRA_MAX_FRAME) begin
                            // Overflow: partial out, offender dropped
                            push = 1'b1;
                            push_rec.len = s_reg.frame_len;
                            push_rec.rx_err = 1'b1;
                            s_next.in_frame = 1'b0;
                            s_next.flushing = 1'b1;
                            s_next.too_long = 1'b1;
                        end else begin
                            s_next.frame_len = `FRA_FRAME_W'(sum);
                            if (head_frag.last_piece_flag) begin
                                push = 1'b1;
                                push_rec.len = `FRA_FRAME_W'(sum);
                                s_next.in_frame = 1'b0;
                            end
                        end
                        if (pop) begin
                            s_next.expected_seq = s_reg.expected_seq + 1'b1;
                            restart = 1'b1;
                        end
                    end else if (seq_less(head_min_seq, s_reg.expected_seq) ||
                                 every_queue_filled || stall_timeout) begin
                        // Sequencing fault handling
                        if (seq_less(head_min_seq, s_reg.expected_seq)) begin
                            pop = 1'b1;
                            s_next.bad = 1'b1;
                        end else begin
                            s_next.expected_seq = head_min_seq;
                            s_next.lost = 1'b1;
                        end
                        restart = 1'b1;
                        push = 1'b1;
                        push_rec.rx_err = 1'b1;
                        if (s_reg.in_frame) begin
                            push_rec.len = s_reg.frame_len;
                            s_next.in_frame = 1'b0;
                            s_next.flushing = 1'b1;
                        end else begin
                            push_rec.len = `FRA_SUBST_LEN;
                            push_rec.substitute = 1'b1;
                        end
                    end
                end
                default: begin
                    s_next.st = FRA_INIT_STATE;
                end
            endcase
        end

        // Leave the head queue when a fragment is consumed
        for (int i = 0; i < NCH; i++) begin
            if (pop && head_ch == ($clog2(NCH+1))'(i)) begin
                s_next.rd[i] = (s_reg.rd[i] == AW'(QDEPTH - 1)) ? '0 : s_reg.rd[i] + 1'b1;
                s_next.cnt[i] = s_reg.cnt[i] - 1'b1;
                s_next.fill_bits[i] = s_reg.fill_bits[i] - to_bits(head_frag.len);
            end
        end

        // Per-channel intake: only good fragments are queued
        for (int i = 0; i < NCH; i++) begin
            if (chan_in_valid[i] && channel_link_up[i]) begin
                if (chan_in_bad[i] ||
                    chan_in_frag[i].len < `FRA_MIN_PIECE ||
                    chan_in_frag[i].len > `FRA_LARGEST_PIECE ||
                    s_reg.cnt[i] == (AW+1)'(QDEPTH) ||
                    s_reg.fill_bits[i] + to_bits(chan_in_frag[i].len) >
                    `FRA_CHAN_BUF_BITS) begin
                    s_next.dropped[i] = 1'b1;
                end else begin
                    s_next.mem[i][s_reg.wr[i]] = chan_in_frag[i];
                    s_next.wr[i] = (s_reg.wr[i] == AW'(QDEPTH - 1)) ? '0 : s_reg.wr[i] + 1'b1;
                    s_next.cnt[i] = s_next.cnt[i] + 1'b1;
                    s_next.fill_bits[i] = s_next.fill_bits[i] + to_bits(chan_in_frag[i].len);
                end
            end
        end

        // Bit-time timers per queue, at that channel's own rate
        for (int i = 0; i < NCH; i++) begin
            if (restart || !channel_link_up[i] || s_reg.cnt[i] == '0) begin
                s_next.div[i] = '0;
                s_next.tmr[i] = '0;
            end else if (s_reg.tmr[i] < SKEW_BITS) begin
                if (s_reg.div[i] + 1'b1 >= chan_bit_div[i]) begin
                    s_next.div[i] = '0;
                    s_next.tmr[i] = s_reg.tmr[i] + 1'b1;
                end else begin
                    s_next.div[i] = s_reg.div[i] + 1'b1;
                end
            end
        end

        // Dropped links take their queued fragments with them
        for (int i = 0; i < NCH; i++) begin
            if (!channel_link_up[i]) begin
                s_next.rd[i] = '0;
                s_next.wr[i] = '0;
                s_next.cnt[i] = '0;
                s_next.fill_bits[i] = '0;
            end
        end

        // First link-up from all-down restarts sequencing
        if (!(|channel_link_up) || !s_reg.link_any) begin
            s_next.st = FRA_INIT_STATE;
            s_next.in_frame = 1'b0;
            s_next.flushing = 1'b0;
            s_next.frame_len = '0;
        end

        // Output register: refill from FIFO when empty or taken
        if (fifo_out_valid && fifo_out_ready) begin
            s_next.out_valid = 1'b1;
            s_next.out_rec = fra_rec_t'(fifo_out_data);
        end else if (mac_out_ready) begin
            s_next.out_valid = 1'b0;
        end
    end

    assign fifo_out_ready = !s_reg.out_valid || mac_out_ready;

    // Records queue up ahead of the rate matcher; full stalls sequencing
    fra_fifo #(
        .WIDTH(RW),
        .DEPTH(ODEPTH)
    ) u_out_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_rec),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Register the whole state
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state record
    assign mac_out_valid = s_reg.out_valid;
    assign mac_out_rec = s_reg.out_rec;
    assign frag_dropped = s_reg.dropped;
    assign seq_known = (s_reg.st == FRA_RUN);
    assign bad_fragment = s_reg.bad;
    assign lost_fragment = s_reg.lost;
    assign lost_first_flag = s_reg.lost_first;
    assign reassembly_too_long = s_reg.too_long;
    assign early_start_seen = s_reg.early;
    assign stray_end_seen = s_reg.stray;
    assign absent_start_seen = s_reg.absent;

endmodule : fra_receiver

`default_nettype wire

// [dv/fra_rx_monitor.sv]
// Checker on the receiver's ports: drops, event pulses, output records.
// Assumes it is bound into every fra_receiver instance.
`timescale 1ns/1ps
`default_nettype none
module fra_rx_monitor #(parameter int NCH = 4) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [NCH-1:0] channel_link_up,
    input wire logic [NCH-1:0] chan_in_valid,
    input wire logic [NCH-1:0] chan_in_bad,
    input wire fra_pkg::fra_frag_t [NCH-1:0] chan_in_frag,
    input wire logic mac_out_ready,
    input wire logic mac_out_valid,
    input wire fra_pkg::fra_rec_t mac_out_rec,
    input wire logic [NCH-1:0] frag_dropped,
    input wire logic seq_known,
    input wire logic bad_fragment,
    input wire logic lost_fragment,
    input wire logic lost_first_flag,
    input wire logic reassembly_too_long,
    input wire logic stray_end_seen,
    input wire logic absent_start_seen
);
    import fra_pkg::*;
    // One clock domain, so one default clocking and reset
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    drop_bad_a: assert property (
        chan_in_valid[0] && channel_link_up[0] && chan_in_bad[0] |=> frag_dropped[0])
        else $error("bad fragment queued");
    drop_size_a: assert property (
        chan_in_valid[0] && channel_link_up[0] && (chan_in_frag[0].len < 10'h040
        || chan_in_frag[0].len > 10'h200) |=> frag_dropped[0]) else $error("odd size queued");
    seq_quiet_a: assert property (
        bad_fragment || lost_fragment |-> $past(seq_known))
        else $error("fault while unknown");
    link_init_a: assert property (
        $rose(|channel_link_up) |-> ##[1:2] !seq_known) else $error("link-up kept old sequence");
    rec_hold_a: assert property (
        mac_out_valid && !mac_out_ready |=> mac_out_valid && $stable(mac_out_rec))
        else $error("record not held");
    subst_len_a: assert property (
        mac_out_valid && mac_out_rec.substitute |-> mac_out_rec.len == 11'h040
        && mac_out_rec.rx_err) else $error("bad substitute");
    lost_start_a: assert property (
        absent_start_seen |-> lost_first_flag) else $error("no lost-start flag");
    stray_end_a: assert property (
        stray_end_seen |-> absent_start_seen) else $error("stray end alone");
    good_len_a: assert property (
        mac_out_valid && !mac_out_rec.rx_err |-> mac_out_rec.len >= 11'h040
        && mac_out_rec.len <= 11'h5F2) else $error("good length out of range");
    // Main scenarios reached
    known_c: cover property ($rose(seq_known));
    subst_c: cover property (mac_out_valid && mac_out_ready && mac_out_rec.substitute);
    long_c: cover property (reassembly_too_long);
    lost_c: cover property (lost_fragment);
endmodule : fra_rx_monitor
bind fra_receiver fra_rx_monitor #(.NCH(NCH)) i_fra_rx_monitor (.mclk, .sys_rst,
    .channel_link_up, .chan_in_valid, .chan_in_bad, .chan_in_frag, .mac_out_ready,
    .mac_out_valid, .mac_out_rec, .frag_dropped, .seq_known, .bad_fragment, .lost_fragment,
    .lost_first_flag, .reassembly_too_long, .stray_end_seen, .absent_start_seen);
`default_nettype wire

// [dv/fra_far_end.sv]
// Far-side model: loop channel senders and the rate matcher sink.
// Assumes the bench seeds $urandom before traffic starts.
`timescale 1ns/1ps
`default_nettype none
module fra_far_end #(parameter int NCH = 2) (
    input wire logic mclk,
    input wire logic stall,
    output logic [NCH-1:0] valid,
    output logic [NCH-1:0] bad,
    output fra_pkg::fra_frag_t [NCH-1:0] frag,
    output logic ready
);
    import fra_pkg::*;
    initial {valid, bad, frag, ready} = '0;
    // Sink stalls at random, fully under stall
    always @(posedge mclk) begin
        ready <= !stall && ($urandom % 4 != 0);
    end
    // One header beat: sequence, start flag, end flag
    // Headers go out singly, so skew and rate ratio stay in limits
    task automatic send(input int ch, input fra_frag_t f, input logic b);
        @(posedge mclk);
        valid[ch] <= 1'b1;
        frag[ch] <= f;
        bad[ch] <= b;
        @(posedge mclk);
        valid[ch] <= 1'b0;
        frag[ch] <= ~f;  // Released lines show no stale header
        repeat (3) @(posedge mclk);
    endtask : send
endmodule : fra_far_end
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the reassembly receiver with a reference model.
// Assumes fra_pkg, fra_receiver and fra_far_end are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fra_pkg::*;
    localparam int NCH = 2;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic stall = 1'b0;
    logic [NCH-1:0] link_up = '0;
    logic [NCH-1:0][15:0] bit_div = '0;
    logic [NCH-1:0] valid, bad, dropped;
    fra_frag_t [NCH-1:0] frag;
    logic ready, out_valid, known;
    fra_rec_t rec;
    wire [6:0] pulses;
    int errors = 0;
    int n_compared = 0;
    int seen_cnt[8], exp_cnt[8];
    logic [12:0] exp_q[$];
    int exp_seq, acc;
    bit known_m, in_frame, flushing;
    initial forever #20 mclk = ~mclk;
    fra_receiver #(.NCH(NCH), .SKEW_BITS(14'h0014)) i_fra_receiver (.mclk,
        .sys_rst, .channel_link_up(link_up), .chan_in_valid(valid), .chan_in_bad(bad),
        .chan_in_frag(frag), .chan_bit_div(bit_div), .mac_out_ready(ready),
        .mac_out_valid(out_valid), .mac_out_rec(rec), .frag_dropped(dropped), .seq_known(known),
        .bad_fragment(pulses[0]), .lost_fragment(pulses[1]), .lost_first_flag(pulses[2]),
        .reassembly_too_long(pulses[3]), .early_start_seen(pulses[4]),
        .stray_end_seen(pulses[5]), .absent_start_seen(pulses[6]));
    fra_far_end #(.NCH(NCH)) i_fra_far_end (.mclk, .stall, .valid, .bad, .frag, .ready);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    // Tally pulses and drops; each taken record meets the model's next one
    always @(posedge mclk) begin
        if (!sys_rst) begin
            for (int i = 0; i < 7; i++) seen_cnt[i] += pulses[i];
            seen_cnt[7] += dropped[0] + dropped[1];
            if (out_valid === 1'b1 && ready === 1'b1) begin
                check("record", rec, exp_q.size() ? exp_q.pop_front() : 32'hDEAD);
            end
        end
    end
    function automatic void push(input int l, input bit e, input bit s);
        exp_q.push_back({11'(l), e, s});
    endfunction : push
    // Error record: partial frame then flush, or substitute between frames
    function automatic void fault();
        if (in_frame) begin
            push(acc, 1, 0);
            flushing = 1;
        end else begin
            push(64, 1, 1);
        end
        in_frame = 0;
    endfunction : fault
    // Reference sequencing and reassembly, fragments in head order
    function automatic void model(input int seq, input bit sop, input bit eop, input int len);
        int d;
        if (!known_m) exp_seq = seq;
        known_m = 1;
        d = (seq - exp_seq) & 14'h3FFF;
        if (d >= 14'h2000) begin
            exp_cnt[0]++;
            fault();
            return;
        end
        if (d != 0) begin
            exp_cnt[1]++;
            fault();
        end
        exp_seq = (seq + 1) & 14'h3FFF;
        if (in_frame && sop) begin
            exp_cnt[4]++;
            push(acc, 1, 0);
            in_frame = 0;
        end
        if (in_frame && acc + len > 1522) begin
            exp_cnt[3]++;
            fault();
        end else if (in_frame || sop) begin
            acc = (in_frame ? acc : 0) + len;
            flushing = flushing && !sop;
            in_frame = !eop;
            if (eop) push(acc, 0, 0);
        end else if (!flushing) begin
            exp_cnt[2]++;
            exp_cnt[6]++;
            exp_cnt[5] += eop;
            push(64, 1, 1);
        end
    endfunction : model
    task automatic wait_out();
        for (int i = 0; i < 300 && exp_q.size() != 0 && !stall; i++) @(posedge mclk);
    endtask : wait_out
    task automatic sendm(input int seq, input bit sop, input bit eop, input int len);
        model(seq, sop, eop, len);
        i_fra_far_end.send(0, {14'(seq), sop, eop, 10'(len)}, 1'b0);
        wait_out();
    endtask : sendm
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h0000_6781));
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        link_up <= 2'b01;
        bit_div <= {16'h0001, 16'h0001};
        sendm(5, 1, 1, 64 + $urandom % 449);
        sendm(6, 1, 0, 512);
        sendm(7, 0, 1, 200);
        // Failed, short and long fragments are dropped
        for (int k = 0; k < 3; k++) begin
            i_fra_far_end.send(0, {14'h0008, 2'b11, k == 0 ? 10'h03F : k == 1 ? 10'h201 : 10'h064}, k == 2);
            exp_cnt[7]++;
        end
        sendm(8, 0, 0, 64);
        sendm(9, 0, 1, 64);
        sendm(10, 1, 0, 512);
        sendm(11, 0, 0, 512);
        sendm(12, 0, 0, 499);
        sendm(13, 0, 1, 64);
        sendm(14, 1, 0, 512);
        sendm(15, 0, 0, 512);
        sendm(16, 0, 1, 498);
        sendm(17, 1, 0, 100);
        sendm(18, 1, 1, 80);
        sendm(14'h2013, 1, 1, 64);
        sendm(14'h2012, 1, 1, 64);
        sendm(14'h3FFF, 1, 1, 64);
        sendm(0, 1, 1, 64);
        // All links down, then two up: start-up waits on the skew timer
        link_up <= 2'b00;
        repeat (4) @(posedge mclk);
        link_up <= 2'b11;
        bit_div[1] <= 16'(1 + $urandom % 3);
        known_m = 0;
        model(100, 1, 1, 64);
        i_fra_far_end.send(0, {14'h0064, 2'b11, 10'h040}, 1'b0);
        check("seq_known", known, 0);
        wait_out();
        sendm(102, 1, 1, 64);
        model(104, 1, 0, 64);
        model(105, 0, 1, 64);
        i_fra_far_end.send(1, {14'h0068, 2'b10, 10'h040}, 1'b0);
        i_fra_far_end.send(0, {14'h0069, 2'b01, 10'h040}, 1'b0);
        wait_out();
        // Sink stalls until the record FIFO refuses, then drains
        stall <= 1'b1;
        for (int k = 0; k < 10; k++) sendm(106 + k, 1, 1, 64 + 4 * k);
        stall <= 1'b0;
        @(posedge mclk);
        wait_out();
        repeat (10) @(posedge mclk);
        check("pending", exp_q.size(), 0);
        for (int i = 0; i < 8; i++) check("event count", seen_cnt[i], exp_cnt[i]);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
